// ### vic_pkg.sv
`default_nettype none
package vic_pkg;

   // -----------------------------------------------------------------
   // Coprocessor address of each register
   // -----------------------------------------------------------------
   localparam logic [3:0] VIC_CP_NUM = 4'hf;
   localparam logic [2:0] VIC_INJ_OPC1 = 3'h0;
   localparam logic [3:0] VIC_INJ_CRN = 4'hc;
   localparam logic [3:0] VIC_INJ_CRM = 4'h1;
   localparam logic [2:0] VIC_INJ_OPC2 = 3'h1;
   localparam logic [2:0] VIC_ISV_OPC1 = 3'h0;
   localparam logic [3:0] VIC_ISV_CRN = 4'hc;
   localparam logic [3:0] VIC_ISV_CRM = 4'h1;
   localparam logic [2:0] VIC_ISV_OPC2 = 3'h0;
   localparam logic [2:0] VIC_CTX_OPC1 = 3'h0;
   localparam logic [3:0] VIC_CTX_CRN = 4'hd;
   localparam logic [3:0] VIC_CTX_CRM = 4'h0;
   localparam logic [2:0] VIC_CTX_OPC2 = 3'h1;
   localparam logic [2:0] VIC_PBR_OPC1 = 3'h4;
   localparam logic [3:0] VIC_PBR_CRN = 4'hf;
   localparam logic [3:0] VIC_PBR_CRM = 4'h0;
   localparam logic [2:0] VIC_PBR_OPC2 = 3'h0;

   // -----------------------------------------------------------------
   // Field positions and reset values
   // -----------------------------------------------------------------
   localparam int VIC_ABORT_BIT = 8;
   localparam int VIC_IRQ_BIT = 7;
   localparam int VIC_FAST_BIT = 6;
   localparam int VIC_BASE_LSB = 13;
   localparam int VIC_BASE_W = 19;
   localparam logic [31:0] VIC_CTX_RESET = 32'h0000_0000;
   localparam logic [VIC_BASE_W-1:0] VIC_BASE_RESET = 19'h0_0000;

   // -----------------------------------------------------------------
   // Carriers
   // -----------------------------------------------------------------
   typedef struct packed {
      logic valid;
      logic write;
      logic [3:0] cpNum;
      logic [2:0] opc1;
      logic [3:0] crn;
      logic [3:0] crm;
      logic [2:0] opc2;
      logic [31:0] wdata;
   } vic_cp_req_s;

   typedef struct packed {
      logic valid;
      logic undef;
      logic [31:0] rdata;
   } vic_cp_rsp_s;

   // Abort, IRQ, fast interrupt, in that order
   typedef struct packed {
      logic abort;
      logic irq;
      logic fastIrq;
   } vic_exc_s;

endpackage : vic_pkg
`default_nettype wire

// ### vic_regs.sv
// Operation
// - Registers reachable only from privileged modes.
// - One copy of each register, shared by both security states.
// - Virtual abort bit 8 pends only with abort routing and override set.
// - Virtual abort taken only in Non-secure state with abort mask clear.
// - Virtual IRQ bit 7 pends only with IRQ routing and override set.
// - Virtual IRQ taken only in Non-secure state with IRQ mask clear.
// - Virtual fast interrupt bit 6 pends only with its routing and override.
// - Virtual fast interrupt taken only Non-secure with its mask clear.
// - Taking a virtual abort clears its request bit automatically.
// - Taking virtual IRQ or fast interrupt leaves its request bit alone.
// - Pending virtual events wake from low-power waits like physical ones.
// - Injection register sits at cp15, 0, c12, c1, 1.
// - Injection bits 31:9 and 5:0 read zero, writes ignored.
// - Whole context identifier goes to debug and trace as context tag.
// - Context identifier sits at cp15, 0, c13, c0, 1.
// - Peripheral base input bits 31:13 captured into base register on the first edge after reset release.
// - Base register read-only at cp15, 4, c15, c0, 0.
// - Status view: virtual when Non-secure, routed and overridden, else physical.
// - Status view keeps a virtual event until its request bit is cleared.
`timescale 1ns/1ps
`default_nettype none
module vic_regs
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Coprocessor transfer port
   input wire vic_pkg::vic_cp_req_s cpReq,
   input wire logic privMode,
   output vic_pkg::vic_cp_rsp_s cpRsp,
   // Security state, routing, override and status mask flags
   input wire logic nonSecure,
   input wire vic_pkg::vic_exc_s routing,
   input wire vic_pkg::vic_exc_s maskOverride,
   input wire vic_pkg::vic_exc_s maskFlag,
   // Physical exceptions pending
   input wire vic_pkg::vic_exc_s physPending,
   // Virtual exceptions offered to and taken by the core
   output vic_pkg::vic_exc_s virtTake,
   input wire vic_pkg::vic_exc_s virtTaken,
   // Interrupt status view and wake
   output vic_pkg::vic_exc_s statusView,
   output logic wakeRequest,
   // Context tag to debug and trace
   output logic [31:0] contextTag,
   // Peripheral base strap
   input wire logic [31:0] peripheralBaseInput,
   output logic [31:0] peripheralBase
);
   import vic_pkg::*;

   // -----------------------------------------------------------------
   // Decode
   // -----------------------------------------------------------------
   function automatic logic hit(input vic_cp_req_s r, input logic [2:0] o1,
                                input logic [3:0] n, input logic [3:0] m,
                                input logic [2:0] o2);
      hit = r.cpNum == VIC_CP_NUM && r.opc1 == o1 && r.crn == n
            && r.crm == m && r.opc2 == o2;
   endfunction : hit

   logic hitInj;
   logic hitIsv;
   logic hitCtx;
   logic hitPbr;
   logic reqOk;
   logic badReq;
   logic wrInj;
   logic wrCtx;

   assign hitInj = hit(cpReq, VIC_INJ_OPC1, VIC_INJ_CRN, VIC_INJ_CRM,
                       VIC_INJ_OPC2);
   assign hitIsv = hit(cpReq, VIC_ISV_OPC1, VIC_ISV_CRN, VIC_ISV_CRM,
                       VIC_ISV_OPC2);
   assign hitCtx = hit(cpReq, VIC_CTX_OPC1, VIC_CTX_CRN, VIC_CTX_CRM,
                       VIC_CTX_OPC2);
   assign hitPbr = hit(cpReq, VIC_PBR_OPC1, VIC_PBR_CRN, VIC_PBR_CRM,
                       VIC_PBR_OPC2);

   // Unknown encodings and the status view write also fault
   assign badReq = cpReq.valid && (!privMode
      || (cpReq.write && (hitPbr || hitIsv))
      || !(hitInj || hitIsv || hitCtx || hitPbr));
   assign reqOk = cpReq.valid && !badReq;
   // Security state plays no part: one shared copy
   assign wrInj = reqOk && cpReq.write && hitInj;
   assign wrCtx = reqOk && cpReq.write && hitCtx;

   // -----------------------------------------------------------------
   // Injection register
   // -----------------------------------------------------------------
   logic virtAbortRequest;
   logic virtIrqRequest;
   logic virtFastIrqRequest;

   // A software write wins over the hardware clear in the same cycle
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         virtAbortRequest <= 1'b0;
      end
      else if (wrInj)
      begin
         virtAbortRequest <= cpReq.wdata[VIC_ABORT_BIT];
      end
      else if (virtTaken.abort)
      begin
         virtAbortRequest <= 1'b0;
      end
   end

   // Taking these leaves the bit set; the handler clears it
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         virtIrqRequest <= 1'b0;
         virtFastIrqRequest <= 1'b0;
      end
      else if (wrInj)
      begin
         virtIrqRequest <= cpReq.wdata[VIC_IRQ_BIT];
         virtFastIrqRequest <= cpReq.wdata[VIC_FAST_BIT];
      end
   end

   a_inj_write: assert property (
      @(posedge clk) disable iff (rst)
      wrInj |=> virtAbortRequest == $past(cpReq.wdata[VIC_ABORT_BIT])
         && virtIrqRequest == $past(cpReq.wdata[VIC_IRQ_BIT])
         && virtFastIrqRequest == $past(cpReq.wdata[VIC_FAST_BIT]))
      else $error("injection write did not land");

   // -----------------------------------------------------------------
   // Pending, taking, status view, wake
   // -----------------------------------------------------------------
   vic_exc_s virtPend;

   assign virtPend.abort = virtAbortRequest && routing.abort
                           && maskOverride.abort;
   assign virtPend.irq = virtIrqRequest && routing.irq
                         && maskOverride.irq;
   assign virtPend.fastIrq = virtFastIrqRequest && routing.fastIrq
                             && maskOverride.fastIrq;

   assign virtTake.abort = virtPend.abort && nonSecure
                           && !maskFlag.abort;
   assign virtTake.irq = virtPend.irq && nonSecure
                         && !maskFlag.irq;
   assign virtTake.fastIrq = virtPend.fastIrq && nonSecure
                             && !maskFlag.fastIrq;

   // The view tracks the request bit, not the take, so it holds until
   // software clears the bit, or for abort until the take clears it
   assign statusView.abort = (nonSecure && routing.abort
      && maskOverride.abort) ? virtAbortRequest
      : physPending.abort;
   assign statusView.irq = (nonSecure && routing.irq
      && maskOverride.irq) ? virtIrqRequest
      : physPending.irq;
   assign statusView.fastIrq = (nonSecure && routing.fastIrq
      && maskOverride.fastIrq) ? virtFastIrqRequest
      : physPending.fastIrq;

   // Wake ignores the status masks, as physical events do
   assign wakeRequest = |virtPend || |physPending;

   a_view_secure: assert property (
      @(posedge clk) disable iff (rst)
      !nonSecure |-> statusView == physPending)
      else $error("status view not physical in Secure state");

   // -----------------------------------------------------------------
   // Context identifier
   // -----------------------------------------------------------------
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         contextTag <= VIC_CTX_RESET;
      end
      else if (wrCtx)
      begin
         contextTag <= cpReq.wdata;
      end
   end

   // -----------------------------------------------------------------
   // Peripheral base, caught on the first edge after reset release
   // -----------------------------------------------------------------
   logic baseCaught;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         baseCaught <= 1'b0;
         peripheralBase <= {VIC_BASE_RESET, 13'h0};
      end
      else if (!baseCaught)
      begin
         baseCaught <= 1'b1;
         peripheralBase <= {peripheralBaseInput[31:VIC_BASE_LSB],
                            13'h0};
      end
   end

   // -----------------------------------------------------------------
   // Read data and answer
   // -----------------------------------------------------------------
   logic [31:0] next_rdata;

   always_comb
   begin
      next_rdata = 32'h0000_0000;
      if (hitInj)
      begin
         next_rdata[VIC_ABORT_BIT] = virtAbortRequest;
         next_rdata[VIC_IRQ_BIT] = virtIrqRequest;
         next_rdata[VIC_FAST_BIT] = virtFastIrqRequest;
      end
      else if (hitIsv)
      begin
         next_rdata[VIC_ABORT_BIT] = statusView.abort;
         next_rdata[VIC_IRQ_BIT] = statusView.irq;
         next_rdata[VIC_FAST_BIT] = statusView.fastIrq;
      end
      else if (hitCtx)
      begin
         next_rdata = contextTag;
      end
      else if (hitPbr)
      begin
         next_rdata = peripheralBase;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         cpRsp <= '0;
      end
      else
      begin
         cpRsp.valid <= cpReq.valid;
         cpRsp.undef <= badReq;
         cpRsp.rdata <= (reqOk && !cpReq.write) ? next_rdata
                        : 32'h0000_0000;
      end
   end

   a_ctx_readback: assert property (
      @(posedge clk) disable iff (rst)
      reqOk && !cpReq.write && hitCtx
      |=> cpRsp.rdata == $past(contextTag))
      else $error("context identifier read returned wrong value");

   a_base_read: assert property (
      @(posedge clk) disable iff (rst)
      reqOk && !cpReq.write && hitPbr
      |=> cpRsp.rdata == $past(peripheralBase))
      else $error("base register read returned wrong value");

   a_fault_inert: assert property (
      @(posedge clk) disable iff (rst)
      badReq |=> $stable(contextTag) && $stable(virtIrqRequest)
         && $stable(virtFastIrqRequest))
      else $error("refused access changed a register");

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   a_user_faults: assert property (
      @(posedge clk) disable iff (rst)
      cpReq.valid && !privMode |=> cpRsp.valid && cpRsp.undef
         && cpRsp.rdata == 32'h0000_0000)
      else $error("user mode access did not fault");

   a_base_readonly: assert property (
      @(posedge clk) disable iff (rst)
      cpReq.valid && privMode && cpReq.write && hitPbr
      |=> cpRsp.undef && $stable(peripheralBase))
      else $error("write to base register was not refused");

   a_abort_autoclear: assert property (
      @(posedge clk) disable iff (rst)
      virtTaken.abort && !wrInj |=> !virtAbortRequest)
      else $error("virtual abort bit not cleared on take");

   a_irq_bits_kept: assert property (
      @(posedge clk) disable iff (rst)
      (virtTaken.irq || virtTaken.fastIrq) && !wrInj
      |=> $stable(virtIrqRequest) && $stable(virtFastIrqRequest))
      else $error("virtual interrupt bit changed on take");

   a_abort_gate: assert property (
      @(posedge clk) disable iff (rst)
      virtTake.abort |-> virtAbortRequest && routing.abort
         && maskOverride.abort && nonSecure && !maskFlag.abort)
      else $error("virtual abort offered without its conditions");

   a_irq_gate: assert property (
      @(posedge clk) disable iff (rst)
      virtTake.irq |-> nonSecure && !maskFlag.irq && routing.irq
         && maskOverride.irq)
      else $error("virtual IRQ offered without its conditions");

   a_fast_gate: assert property (
      @(posedge clk) disable iff (rst)
      virtTake.fastIrq |-> nonSecure && !maskFlag.fastIrq
         && routing.fastIrq && maskOverride.fastIrq)
      else $error("virtual fast interrupt offered without conditions");

   a_reserved_zero: assert property (
      @(posedge clk) disable iff (rst)
      reqOk && !cpReq.write && hitInj
      |=> cpRsp.rdata[31:9] == 23'h00_0000 && cpRsp.rdata[5:0] == 6'h00)
      else $error("injection reserved bits not zero");

   a_ctx_tag: assert property (
      @(posedge clk) disable iff (rst)
      wrCtx |=> contextTag == $past(cpReq.wdata))
      else $error("context tag did not follow the write");

   a_view_holds: assert property (
      @(posedge clk) disable iff (rst)
      nonSecure && routing.irq && maskOverride.irq && virtIrqRequest
      |-> statusView.irq)
      else $error("status view dropped a pending virtual IRQ");

   a_base_capture: assert property (
      @(posedge clk) disable iff (rst)
      !baseCaught |=> peripheralBase[31:13] == $past(
         peripheralBaseInput[31:13]) ##1 $stable(peripheralBase))
      else $error("peripheral base not captured after reset");

   a_wake_virtual: assert property (
      @(posedge clk) disable iff (rst)
      |virtPend |-> wakeRequest)
      else $error("pending virtual event does not wake");

endmodule : vic_regs
`default_nettype wire

// ### vic_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module vic_core_model
(
   // Clock
   input wire logic clk,
   // Coprocessor transfer port
   output vic_pkg::vic_cp_req_s cpReq,
   output logic privMode,
   input wire vic_pkg::vic_cp_rsp_s cpRsp,
   // Exceptions taken
   output vic_pkg::vic_exc_s virtTaken
);
   import vic_pkg::*;
   initial
   begin
      cpReq = '0;
      privMode = 1'b1;
      virtTaken = '0;
   end
   // ----------
   // Transfers
   // ----------
   // Fields are inverted on release so stale values never match
   task automatic xfer(input logic priv, input logic wr,
                       input logic [17:0] a, input logic [31:0] wd,
                       output vic_cp_rsp_s rsp);
      @(negedge clk);
      privMode = priv;
      cpReq = {1'b1, wr, a, wd};
      @(negedge clk);
      rsp = cpRsp;
      cpReq = {1'b0, ~wr, ~a, ~wd};
   endtask : xfer
   // One-cycle take pulse, issued only when the bench commands it
   task automatic take(input vic_exc_s e);
      @(negedge clk);
      virtTaken = e;
      @(negedge clk);
      virtTaken = '0;
   endtask : take
endmodule : vic_core_model
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import vic_pkg::*;
   // ----------
   // Wiring
   // ----------
   localparam logic [17:0] A_INJ = {VIC_CP_NUM, VIC_INJ_OPC1, VIC_INJ_CRN,
                                   VIC_INJ_CRM, VIC_INJ_OPC2};
   localparam logic [17:0] A_CTX = {VIC_CP_NUM, VIC_CTX_OPC1, VIC_CTX_CRN,
                                   VIC_CTX_CRM, VIC_CTX_OPC2};
   localparam logic [17:0] A_PBR = {VIC_CP_NUM, VIC_PBR_OPC1, VIC_PBR_CRN,
                                   VIC_PBR_CRM, VIC_PBR_OPC2};
   localparam logic [17:0] A_ISV = {VIC_CP_NUM, VIC_ISV_OPC1, VIC_ISV_CRN,
                                   VIC_ISV_CRM, VIC_ISV_OPC2};
   localparam logic [17:0] A_BAD = {4'he, A_CTX[13:0]};
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic nonSecure = 1'b0;
   logic privMode;
   logic wakeRequest;
   logic [31:0] contextTag;
   logic [31:0] peripheralBase;
   logic [31:0] peripheralBaseInput = 32'ha5c3_7fff;
   logic [31:0] expBase;
   vic_cp_req_s cpReq;
   vic_cp_rsp_s cpRsp;
   vic_cp_rsp_s rsp;
   vic_exc_s routing = '0;
   vic_exc_s maskOverride = '0;
   vic_exc_s maskFlag = '0;
   vic_exc_s physPending = '0;
   vic_exc_s virtTake;
   vic_exc_s virtTaken;
   vic_exc_s statusView;
   int error_cnt = 0;
   int total_checks = 0;
   always #2.5 clk = ~clk;
   vic_regs i_dut (.clk(clk), .rst(rst), .cpReq(cpReq), .privMode(privMode),
      .cpRsp(cpRsp), .nonSecure(nonSecure), .routing(routing),
      .maskOverride(maskOverride), .maskFlag(maskFlag),
      .physPending(physPending), .virtTake(virtTake), .virtTaken(virtTaken),
      .statusView(statusView), .wakeRequest(wakeRequest),
      .contextTag(contextTag), .peripheralBaseInput(peripheralBaseInput),
      .peripheralBase(peripheralBase));
   vic_core_model i_core (.clk(clk), .cpReq(cpReq), .privMode(privMode),
      .cpRsp(cpRsp), .virtTaken(virtTaken));
   // ----------
   // Helpers
   // ----------
   task automatic chk(input string name, input logic [31:0] seen,
                      input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   task automatic acc(input logic priv, input logic wr,
                      input logic [17:0] a, input logic [31:0] wd,
                      input logic ud, input logic [31:0] rd);
      i_core.xfer(priv, wr, a, wd, rsp);
      chk("rsp.valid", {31'h0, rsp.valid}, 32'h1);
      chk("rsp.undef", {31'h0, rsp.undef}, {31'h0, ud});
      chk("rsp.rdata", rsp.rdata, rd);
   endtask : acc
   task automatic finish_test;
      $display("Checks %0d, mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : finish_test
   // ----------
   // Scenarios
   // ----------
   task automatic t_base;
      expBase = {peripheralBaseInput[31:13], 13'h0};
      chk("peripheralBase", peripheralBase, expBase);
      acc(1'b1, 1'b0, A_PBR, 32'h0, 1'b0, expBase);
      acc(1'b1, 1'b1, A_PBR, 32'hffff_ffff, 1'b1, 32'h0);
      chk("peripheralBase", peripheralBase, expBase);
      $display("Test base done");
   endtask : t_base
   task automatic t_ctx;
      // Process id 00abcd in the top field, address space id 5a below
      acc(1'b1, 1'b1, A_CTX, 32'h00ab_cd5a, 1'b0, 32'h0);
      chk("contextTag", contextTag, 32'h00ab_cd5a);
      nonSecure = 1'b1;
      acc(1'b1, 1'b0, A_CTX, 32'h0, 1'b0, 32'h00ab_cd5a);
      acc(1'b0, 1'b1, A_CTX, 32'hffff_ffff, 1'b1, 32'h0);
      acc(1'b0, 1'b0, A_CTX, 32'h0, 1'b1, 32'h0);
      acc(1'b1, 1'b0, A_BAD, 32'h0, 1'b1, 32'h0);
      chk("contextTag", contextTag, 32'h00ab_cd5a);
      $display("Test context done");
   endtask : t_ctx
   task automatic t_inj;
      logic [2:0] pend;
      logic [2:0] sel;
      acc(1'b0, 1'b1, A_INJ, 32'hffff_ffff, 1'b1, 32'h0);
      acc(1'b1, 1'b0, A_INJ, 32'h0, 1'b0, 32'h0);
      acc(1'b1, 1'b1, A_INJ, 32'hffff_ffff, 1'b0, 32'h0);
      acc(1'b1, 1'b0, A_INJ, 32'h0, 1'b0, 32'h0000_01c0);
      // Every mix of routing, override, mask and state; physical events set to routing xor override
      for (int k = 0; k < 1024; k++)
      begin
         @(negedge clk);
         routing = vic_exc_s'(k[2:0]);
         maskOverride = vic_exc_s'(k[5:3]);
         maskFlag = vic_exc_s'(k[8:6]);
         nonSecure = k[9];
         physPending = vic_exc_s'(k[2:0] ^ k[5:3]);
         #1;
         pend = k[2:0] & k[5:3];
         sel = k[9] ? pend : 3'h0;
         chk("virtTake", {29'h0, virtTake},
             {29'h0, sel & ~k[8:6]});
         chk("statusView", {29'h0, statusView},
             {29'h0, sel | (~sel & physPending)});
         chk("wakeRequest", {31'h0, wakeRequest},
             {31'h0, |(pend | physPending)});
      end
      $display("Test injection done");
   endtask : t_inj
   task automatic t_take;
      @(negedge clk);
      routing = '1;
      maskOverride = '1;
      maskFlag = '0;
      physPending = '0;
      nonSecure = 1'b1;
      i_core.take(3'b100);
      chk("virtTake", {29'h0, virtTake}, 32'h3);
      acc(1'b1, 1'b0, A_INJ, 32'h0, 1'b0, 32'h0000_00c0);
      i_core.take(3'b011);
      acc(1'b1, 1'b0, A_INJ, 32'h0, 1'b0, 32'h0000_00c0);
      chk("statusView", {29'h0, statusView}, 32'h3);
      acc(1'b1, 1'b0, A_ISV, 32'h0, 1'b0, 32'h0000_00c0);
      acc(1'b1, 1'b1, A_ISV, 32'hffff_ffff, 1'b1, 32'h0);
      acc(1'b1, 1'b0, A_INJ, 32'h0, 1'b0, 32'h0000_00c0);
      acc(1'b1, 1'b1, A_INJ, 32'h0, 1'b0, 32'h0);
      chk("statusView", {29'h0, statusView}, 32'h0);
      acc(1'b1, 1'b0, A_ISV, 32'h0, 1'b0, 32'h0);
      $display("Test take done");
   endtask : t_take
   // ----------
   // Sequence
   // ----------
   initial
   begin
      repeat (20) @(negedge clk);
      rst = 1'b0;
      repeat (3) @(negedge clk);
      t_base;
      t_ctx;
      t_inj;
      t_take;
      finish_test;
   end
   // Tests need about 1100 cycles; the limit leaves wide margin
   initial
   begin
      #40000;
      error_cnt++;
      finish_test;
   end
endmodule : tb_top
`default_nettype wire
